/* design/pmpc_map.svh */
`ifndef PMPC_MAP_SVH
`define PMPC_MAP_SVH
`define PMPC_CLK_HZ          250000000
`define PMPC_OFS_CTRL        8'h00
`define PMPC_OFS_DUTY        8'h04
`define PMPC_OFS_THR         8'h08
`define PMPC_OFS_FEEDLEN     8'h0C
`define PMPC_OFS_STATUS      8'h10
`define PMPC_OFS_PERIOD      8'h14
`define PMPC_CTRL_RST        32'h0000_0000
`define PMPC_DUTY_RST        16'h0000
`define PMPC_THR_RST         20'hFFFFF
`define PMPC_FEEDLEN_RST     8'h00
`define PMPC_B_CARR_GO       0
`define PMPC_B_CARR_DIR      1
`define PMPC_B_FEED_RUN      2
`define PMPC_B_FEED_DIR      3
`define PMPC_B_PULL          4
`define PMPC_B_PLG_OPEN      5
`define PMPC_B_GAP_RUN       6
`define PMPC_B_GAP_DIR       7
`define PMPC_B_RIB_DIR       8
`define PMPC_B_CARR_MOVE     9
`define PMPC_B_WDT_EN        10
`define PMPC_B_FEED_HOLD     11
`define PMPC_CTRL_W          12
`define PMPC_BR_OFF          4'h0
`define PMPC_BR_MODE1        4'hA
`define PMPC_BR_MODE3_LR     4'h3
`define PMPC_BR_MODE3_RL     4'hC
`define PMPC_CARR_TIMEOUT_S  1.5
`define PMPC_FEED_NORMAL_PPS 4274
`define PMPC_FEED_MIDDLE_PPS 2610
`define PMPC_FEED_MICRO_PPS  1000
`define PMPC_RIBBON_PPS      720
`define PMPC_GAP_PPS         285
`define PMPC_FEED_LEN_MICRO  8'd20
`define PMPC_FEED_LEN_MIDDLE 8'd60
`define PMPC_WDT_MS          100
`define PMPC_PLG_DRIVE_MS    50
`endif

/* design/pmpc_pkg.sv */
package pmpc_pkg;
  typedef enum logic [1:0] {CARR_IDLE, CARR_DEC12, CARR_DEC3, CARR_SHORT} pmpc_carr_state_type;
  typedef enum logic [1:0] {FEED_MICRO, FEED_MIDDLE, FEED_NORMAL} pmpc_feed_mode_type;
  typedef enum logic [1:0] {PLG_OFF, PLG_DRIVE, PLG_HOLD} pmpc_plg_state_type;
endpackage

/* design/pmpc_stepper.sv */
module pmpc_stepper #(
  parameter int DIV_W   = 20,
  parameter bit HOLD_OK = 1'b1
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rstn_in,
  input  wire logic             run_in,
  input  wire logic             dir_in,
  input  wire logic             half_in,
  input  wire logic             hold_in,
  input  wire logic [DIV_W-1:0] div_in,
  output logic      [3:0]       phase_out,
  output logic                  step_out
);
  logic [2:0]       idx_ff;
  logic [DIV_W-1:0] cnt_ff;
  logic [3:0]       nxt_phase;
  wire              tick = run_in & (cnt_ff >= div_in - DIV_W'(1));
  wire  [2:0]       stride = half_in ? 3'h1 : 3'h2;

  // Eight-state half-step table: A, AB, B, BC, C, CD, D, DA
  function automatic logic [3:0] pmpc_phase(input logic [2:0] i);
    case (i)
      3'h0: pmpc_phase = 4'h1;
      3'h1: pmpc_phase = 4'h3;
      3'h2: pmpc_phase = 4'h2;
      3'h3: pmpc_phase = 4'h6;
      3'h4: pmpc_phase = 4'h4;
      3'h5: pmpc_phase = 4'hC;
      3'h6: pmpc_phase = 4'h8;
      default: pmpc_phase = 4'h9;
    endcase
  endfunction

  // Full step forces an odd index so two adjacent windings stay on
  assign nxt_phase = run_in ? (half_in ? pmpc_phase(idx_ff) : pmpc_phase(idx_ff | 3'h1)) :
                     (hold_in && HOLD_OK) ?
                     (half_in ? pmpc_phase(idx_ff & 3'h6) : pmpc_phase(idx_ff | 3'h1)) :
                     4'h0;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      idx_ff    <= 3'h0;
      cnt_ff    <= '0;
      phase_out <= 4'h0;
      step_out  <= 1'b0;
    end else begin
      cnt_ff    <= (tick || !run_in) ? '0 : cnt_ff + DIV_W'(1);
      idx_ff    <= !tick ? idx_ff : (dir_in ? idx_ff - stride : idx_ff + stride);
      phase_out <= nxt_phase;
      step_out  <= tick;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  property p_idle_off;
    !run_in && !(hold_in && HOLD_OK) |=> phase_out == 4'h0;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle stepper still energised");

  property p_adjacent;
    run_in && !half_in |=> $countones(phase_out) == 2;
  endproperty
  a_adjacent: assert property (p_adjacent) else $error("full step not two-phase");
endmodule

/* design/pmpc_motor_ctrl.sv */
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`include "pmpc_map.svh"
module pmpc_motor_ctrl #(
  parameter int unsigned TIMEOUT_CYC    = int'(`PMPC_CARR_TIMEOUT_S * `PMPC_CLK_HZ),
  parameter int unsigned FEED_NORM_DIV  = `PMPC_CLK_HZ / `PMPC_FEED_NORMAL_PPS,
  parameter int unsigned FEED_MID_DIV   = `PMPC_CLK_HZ / `PMPC_FEED_MIDDLE_PPS,
  parameter int unsigned FEED_MICRO_DIV = `PMPC_CLK_HZ / `PMPC_FEED_MICRO_PPS,
  parameter int unsigned RIBBON_DIV     = `PMPC_CLK_HZ / `PMPC_RIBBON_PPS,
  parameter int unsigned GAP_DIV        = `PMPC_CLK_HZ / `PMPC_GAP_PPS,
  parameter int unsigned WDT_CYC        = `PMPC_WDT_MS * (`PMPC_CLK_HZ / 1000),
  parameter int unsigned PLG_DRIVE_CYC  = `PMPC_PLG_DRIVE_MS * (`PMPC_CLK_HZ / 1000)
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        carriage_encoder_in,
  input  wire logic        encoder_phase_a_in,
  input  wire logic        encoder_phase_b_in,
  input  wire logic        feed_phase_a_monitor_in,
  output logic      [3:0]  carriage_bridge_out,
  output logic      [3:0]  feed_phase_outputs_out,
  output logic      [3:0]  ribbon_phase_outputs_out,
  output logic      [3:0]  gap_phase_outputs_out,
  output logic             gap_drive_hold_select_out,
  output logic             plunger_drive_out,
  output logic             plunger_hold_out,
  output logic             reset_request_n_out
);
  // Bus slave
  logic [`PMPC_CTRL_W-1:0] ctrl_ff;
  logic [7:0]              duty_ff;
  logic [7:0]              first_minimum_duty_ff;
  logic [19:0]             third_speed_threshold_ff;
  logic [7:0]              feed_len_ff;
  logic                    wr_pend_ff;
  logic [7:0]              wr_addr_ff;
  logic [31:0]             rd_data;

  // Pins from outside: carriage enc, gap A, gap B, feed monitor
  logic [3:0]  sync1_ff;
  logic [3:0]  sync2_ff;
  logic [3:0]  prev_ff;

  pmpc_pkg::pmpc_carr_state_type carr_state_ff;
  pmpc_pkg::pmpc_carr_state_type nxt_carr_state;
  pmpc_pkg::pmpc_feed_mode_type  feed_mode;
  pmpc_pkg::pmpc_plg_state_type  plg_state_ff;
  pmpc_pkg::pmpc_plg_state_type  nxt_plg_state;

  logic [31:0] per_cnt_ff;
  logic [31:0] last_per_ff;
  logic [7:0]  pwm_ff;
  logic [3:0]  nxt_bridge;
  logic [15:0] gap_pos_ff;
  logic [31:0] wdt_cnt_ff;
  logic        wdt_trip_ff;
  logic [31:0] plg_cnt_ff;
  logic [19:0] feed_div;

  wire ahb_go   = hsel_in & htrans_in[1] & hready_in;
  wire wr_ctrl  = wr_pend_ff & (wr_addr_ff == `PMPC_OFS_CTRL);
  wire wr_duty  = wr_pend_ff & (wr_addr_ff == `PMPC_OFS_DUTY);
  wire wr_thr   = wr_pend_ff & (wr_addr_ff == `PMPC_OFS_THR);
  wire wr_flen  = wr_pend_ff & (wr_addr_ff == `PMPC_OFS_FEEDLEN);

  wire carr_go   = ctrl_ff[`PMPC_B_CARR_GO];
  wire carr_dir  = ctrl_ff[`PMPC_B_CARR_DIR];
  wire feed_run  = ctrl_ff[`PMPC_B_FEED_RUN];
  wire feed_hold = ctrl_ff[`PMPC_B_FEED_HOLD];
  wire gap_run   = ctrl_ff[`PMPC_B_GAP_RUN];
  wire plg_open  = ctrl_ff[`PMPC_B_PLG_OPEN];
  wire wdt_en    = ctrl_ff[`PMPC_B_WDT_EN];

  wire carr_edge = sync2_ff[0] & ~prev_ff[0];
  wire mon_edge  = sync2_ff[3] ^ prev_ff[3];
  wire qa        = sync2_ff[1];
  wire qb        = sync2_ff[2];
  wire q_valid   = (qa ^ prev_ff[1]) ^ (qb ^ prev_ff[2]);
  wire q_fwd     = ~(prev_ff[1] ^ qb);
  wire slow      = (last_per_ff >= 32'(third_speed_threshold_ff)) |
                   (per_cnt_ff >= 32'(third_speed_threshold_ff));
  wire stalled   = per_cnt_ff >= TIMEOUT_CYC;
  wire mode2_on  = pwm_ff < duty_ff;
  wire duty_min  = duty_ff <= first_minimum_duty_ff;
  wire ribbon_run = ctrl_ff[`PMPC_B_CARR_MOVE] | (carr_state_ff != pmpc_pkg::CARR_IDLE);
  wire wdt_expire = wdt_cnt_ff >= WDT_CYC;
  wire plg_done   = plg_cnt_ff >= PLG_DRIVE_CYC - 32'd1;

  assign rd_data = (haddr_in[7:0] == `PMPC_OFS_CTRL)    ? 32'(ctrl_ff) :
                   (haddr_in[7:0] == `PMPC_OFS_DUTY)    ? {16'h0000, first_minimum_duty_ff,
                                                           duty_ff} :
                   (haddr_in[7:0] == `PMPC_OFS_THR)     ? 32'(third_speed_threshold_ff) :
                   (haddr_in[7:0] == `PMPC_OFS_FEEDLEN) ? 32'(feed_len_ff) :
                   (haddr_in[7:0] == `PMPC_OFS_STATUS)  ? {gap_pos_ff, 9'h000, wdt_trip_ff,
                                                           duty_min, 1'b0, feed_mode,
                                                           carr_state_ff} :
                   (haddr_in[7:0] == `PMPC_OFS_PERIOD)  ? last_per_ff : 32'h0000_0000;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      wr_pend_ff    <= 1'b0;
      wr_addr_ff    <= 8'h00;
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      wr_pend_ff <= ahb_go & hwrite_in;
      wr_addr_ff <= haddr_in[7:0];
      hrdata_out <= (ahb_go & ~hwrite_in) ? rd_data : hrdata_out;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      ctrl_ff                  <= `PMPC_CTRL_W'(`PMPC_CTRL_RST);
      {first_minimum_duty_ff, duty_ff} <= `PMPC_DUTY_RST;
      third_speed_threshold_ff <= `PMPC_THR_RST;
      feed_len_ff              <= `PMPC_FEEDLEN_RST;
    end else begin
      if (wr_ctrl) ctrl_ff <= hwdata_in[`PMPC_CTRL_W-1:0];
      if (wr_duty) {first_minimum_duty_ff, duty_ff} <= hwdata_in[15:0];
      if (wr_thr) third_speed_threshold_ff <= hwdata_in[19:0];
      if (wr_flen) feed_len_ff <= hwdata_in[7:0];
    end
  end

  // Chain keeps tracking the pins through reset so no false edge follows release
  always_ff @(posedge ref_clk_in) begin
    sync1_ff <= {feed_phase_a_monitor_in, encoder_phase_b_in, encoder_phase_a_in,
                 carriage_encoder_in};
    sync2_ff <= sync1_ff;
    prev_ff  <= sync2_ff;
  end

  // Carriage deceleration; acceleration and speed loop live elsewhere
  always_comb begin
    nxt_carr_state = carr_state_ff;
    case (carr_state_ff)
      pmpc_pkg::CARR_IDLE:  if (carr_go) nxt_carr_state = pmpc_pkg::CARR_DEC12;
      pmpc_pkg::CARR_DEC12: begin
        if (!carr_go) nxt_carr_state = pmpc_pkg::CARR_IDLE;
        else if (slow) nxt_carr_state = pmpc_pkg::CARR_DEC3;
      end
      pmpc_pkg::CARR_DEC3:  begin
        if (!carr_go) nxt_carr_state = pmpc_pkg::CARR_IDLE;
        else if (stalled) nxt_carr_state = pmpc_pkg::CARR_SHORT;
      end
      pmpc_pkg::CARR_SHORT: if (!carr_go) nxt_carr_state = pmpc_pkg::CARR_IDLE;
      default: nxt_carr_state = pmpc_pkg::CARR_IDLE;
    endcase
  end

  assign nxt_bridge =
    (carr_state_ff == pmpc_pkg::CARR_DEC12) ? (mode2_on ? `PMPC_BR_OFF : `PMPC_BR_MODE1) :
    (carr_state_ff == pmpc_pkg::CARR_DEC3) ?
    (carr_dir ? `PMPC_BR_MODE3_RL : `PMPC_BR_MODE3_LR) :
    (carr_state_ff == pmpc_pkg::CARR_SHORT) ? `PMPC_BR_MODE1 : `PMPC_BR_OFF;

  // Period counter saturates so a stopped carriage never wraps back to fast
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      carr_state_ff       <= pmpc_pkg::CARR_IDLE;
      per_cnt_ff          <= 32'h0000_0000;
      last_per_ff         <= 32'hFFFF_FFFF;
      pwm_ff              <= 8'h00;
      carriage_bridge_out <= `PMPC_BR_OFF;
    end else begin
      carr_state_ff <= nxt_carr_state;
      if (carr_edge) begin
        per_cnt_ff  <= 32'h0000_0000;
        last_per_ff <= per_cnt_ff;
      end else if (per_cnt_ff != 32'hFFFF_FFFF) begin
        per_cnt_ff <= per_cnt_ff + 32'd1;
      end
      pwm_ff              <= pwm_ff + 8'h01;
      carriage_bridge_out <= nxt_bridge;
    end
  end

  // Paper feed speed selection from length and pull tractor
  assign feed_mode = (feed_len_ff < `PMPC_FEED_LEN_MICRO) ? pmpc_pkg::FEED_MICRO :
                     ((feed_len_ff < `PMPC_FEED_LEN_MIDDLE) | ctrl_ff[`PMPC_B_PULL]) ?
                     pmpc_pkg::FEED_MIDDLE : pmpc_pkg::FEED_NORMAL;
  assign feed_div  = (feed_mode == pmpc_pkg::FEED_NORMAL) ? 20'(FEED_NORM_DIV) :
                     (feed_mode == pmpc_pkg::FEED_MIDDLE) ? 20'(FEED_MID_DIV) :
                     20'(FEED_MICRO_DIV);

  // Half step while moving, single phase when held, high level energises
  pmpc_stepper #(.DIV_W(20), .HOLD_OK(1'b1)) u_feed (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .run_in     (feed_run),
    .dir_in     (ctrl_ff[`PMPC_B_FEED_DIR]),
    .half_in    (1'b1),
    .hold_in    (feed_hold),
    .div_in     (feed_div),
    .phase_out  (feed_phase_outputs_out),
    .step_out   ()
  );

  pmpc_stepper #(.DIV_W(20), .HOLD_OK(1'b0)) u_ribbon (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .run_in     (ribbon_run),
    .dir_in     (ctrl_ff[`PMPC_B_RIB_DIR]),
    .half_in    (1'b0),
    .hold_in    (1'b0),
    .div_in     (20'(RIBBON_DIV)),
    .phase_out  (ribbon_phase_outputs_out),
    .step_out   ()
  );

  // Gap motor holds at the low common level between moves
  pmpc_stepper #(.DIV_W(20), .HOLD_OK(1'b1)) u_gap (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .run_in     (gap_run),
    .dir_in     (ctrl_ff[`PMPC_B_GAP_DIR]),
    .half_in    (1'b0),
    .hold_in    (1'b1),
    .div_in     (20'(GAP_DIV)),
    .phase_out  (gap_phase_outputs_out),
    .step_out   ()
  );

  // Double transitions are dropped rather than guessed
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      gap_pos_ff                <= 16'h0000;
      gap_drive_hold_select_out <= 1'b0;
    end else begin
      if (q_valid) gap_pos_ff <= q_fwd ? gap_pos_ff + 16'h0001 : gap_pos_ff - 16'h0001;
      gap_drive_hold_select_out <= gap_run;
    end
  end

  // Watchdog trips only while feed is commanded to run; request stays low until reset
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      wdt_cnt_ff          <= 32'h0000_0000;
      wdt_trip_ff         <= 1'b0;
      reset_request_n_out <= 1'b1;
    end else begin
      if (mon_edge || !(wdt_en && feed_run)) wdt_cnt_ff <= 32'h0000_0000;
      else if (!wdt_expire) wdt_cnt_ff <= wdt_cnt_ff + 32'd1;
      if (wdt_expire) wdt_trip_ff <= 1'b1;
      if (wdt_expire) reset_request_n_out <= 1'b0;
    end
  end

  always_comb begin
    nxt_plg_state = plg_state_ff;
    case (plg_state_ff)
      pmpc_pkg::PLG_OFF:   if (plg_open) nxt_plg_state = pmpc_pkg::PLG_DRIVE;
      pmpc_pkg::PLG_DRIVE: begin
        if (!plg_open) nxt_plg_state = pmpc_pkg::PLG_OFF;
        else if (plg_done) nxt_plg_state = pmpc_pkg::PLG_HOLD;
      end
      pmpc_pkg::PLG_HOLD:  if (!plg_open) nxt_plg_state = pmpc_pkg::PLG_OFF;
      default: nxt_plg_state = pmpc_pkg::PLG_OFF;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      plg_state_ff      <= pmpc_pkg::PLG_OFF;
      plg_cnt_ff        <= 32'h0000_0000;
      plunger_drive_out <= 1'b0;
      plunger_hold_out  <= 1'b0;
    end else begin
      plg_state_ff      <= nxt_plg_state;
      plg_cnt_ff        <= (plg_state_ff == pmpc_pkg::PLG_DRIVE) ? plg_cnt_ff + 32'd1 : 32'd0;
      plunger_drive_out <= nxt_plg_state == pmpc_pkg::PLG_DRIVE;
      plunger_hold_out  <= nxt_plg_state == pmpc_pkg::PLG_HOLD;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  property p_mode2;
    carr_state_ff == pmpc_pkg::CARR_DEC12 && mode2_on |=> carriage_bridge_out == `PMPC_BR_OFF;
  endproperty
  a_mode2: assert property (p_mode2) else $error("mode 2 missing in duty part");

  property p_mode1_rest;
    carr_state_ff == pmpc_pkg::CARR_DEC12 && !mode2_on |=> carriage_bridge_out == 4'hA;
  endproperty
  a_mode1_rest: assert property (p_mode1_rest) else $error("mode 1 missing in rest");

  property p_to_dec3;
    carr_state_ff == pmpc_pkg::CARR_DEC12 && carr_go && slow
      |=> carr_state_ff == pmpc_pkg::CARR_DEC3 ##1 carriage_bridge_out != 4'hA;
  endproperty
  a_to_dec3: assert property (p_to_dec3) else $error("no final braking at threshold");

  property p_dec3;
    carr_state_ff == pmpc_pkg::CARR_DEC3 |=> carriage_bridge_out == ($past(carr_dir) ? 4'hC : 4'h3);
  endproperty
  a_dec3: assert property (p_dec3) else $error("wrong mode 3 bridge");

  property p_stall;
    carr_state_ff == pmpc_pkg::CARR_DEC3 && carr_go && stalled
      |=> ##1 carriage_bridge_out == 4'hA;
  endproperty
  a_stall: assert property (p_stall) else $error("no short brake after timeout");

  property p_feed_hold;
    !feed_run && feed_hold |=> $onehot(feed_phase_outputs_out);
  endproperty
  a_feed_hold: assert property (p_feed_hold) else $error("feed hold not single phase");

  property p_gap_sel;
    $rose(gap_run) |=> gap_drive_hold_select_out ##0 gap_phase_outputs_out != 4'h0;
  endproperty
  a_gap_sel: assert property (p_gap_sel) else $error("gap drive level not selected");

  property p_wdt;
    wdt_expire |=> !reset_request_n_out [*3];
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog request missing");

  property p_quad;
    q_valid && q_fwd |=> gap_pos_ff == $past(gap_pos_ff) + 16'h0001;
  endproperty
  a_quad: assert property (p_quad) else $error("gap count not advanced");

  property p_plg_hold;
    plg_state_ff == pmpc_pkg::PLG_DRIVE && plg_open && plg_done
      |=> plunger_hold_out && !plunger_drive_out;
  endproperty
  a_plg_hold: assert property (p_plg_hold) else $error("plunger not held after drive");
endmodule

/* verification/pmpc_far_side.sv */
module pmpc_far_side (
  input  wire logic        ref_clk_in,
  input  wire logic [3:0]  feed_phase_in,
  input  wire logic        stuck_in,
  input  wire logic [15:0] enc_half_in,
  input  wire logic        quad_step_in,
  input  wire logic        quad_dir_in,
  output logic             carriage_encoder_out,
  output logic             encoder_phase_a_out,
  output logic             encoder_phase_b_out,
  output logic             feed_phase_a_monitor_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] cnt_ff = 16'h0000;
  logic [1:0]  quad_ff = 2'h0;
  initial carriage_encoder_out = 1'b0;
  // A stopped carriage leaves its encoder line at rest
  always @(posedge ref_clk_in) begin
    if (enc_half_in == 16'h0000) begin
      cnt_ff <= 16'h0000;
    end else if (cnt_ff + 16'h0001 >= enc_half_in) begin
      cnt_ff <= 16'h0000;
      carriage_encoder_out <= ~carriage_encoder_out;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
    if (quad_step_in) begin
      quad_ff <= quad_dir_in ? quad_ff - 2'h1 : quad_ff + 2'h1;
    end
  end
  // Gray walk 00,10,11,01 puts phase A ahead of phase B when counting up
  assign encoder_phase_a_out = quad_ff[0] ^ quad_ff[1];
  assign encoder_phase_b_out = quad_ff[1];
  // Winding A readback; a jammed motor leaves it low
  assign feed_phase_a_monitor_out = feed_phase_in[0] & ~stuck_in;
endmodule

/* verification/tb.sv */
`include "pmpc_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FN = 12, FM = 16, RB = 8, GP = 10, WD = 500, PL = 20;
  logic        clk, rstn, hsel, hwrite, stuck, qstep, qdir, up0, up1;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] ehalf;
  logic        hready, hresp, cenc, ea, eb, mon, gsel, pdrv, phld, rreq_n;
  logic [3:0]  bridge, fph, rph, gph;
  logic [7:0]  d;
  logic [7:0]  lens [7] = '{8'h00, 8'h13, 8'h14, 8'h3B, 8'h3C, 8'hFF, 8'h50};
  logic [31:0] seed = 32'h8993E438;
  int          num_errors = 0, samples_checked = 0, n;

  pmpc_motor_ctrl #(.TIMEOUT_CYC(2000), .FEED_NORM_DIV(FN), .FEED_MID_DIV(FM),
    .FEED_MICRO_DIV(20), .RIBBON_DIV(RB), .GAP_DIV(GP), .WDT_CYC(WD), .PLG_DRIVE_CYC(PL)) dut (
    .ref_clk_in(clk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .carriage_encoder_in(cenc), .encoder_phase_a_in(ea), .encoder_phase_b_in(eb),
    .feed_phase_a_monitor_in(mon), .carriage_bridge_out(bridge), .feed_phase_outputs_out(fph),
    .ribbon_phase_outputs_out(rph), .gap_phase_outputs_out(gph),
    .gap_drive_hold_select_out(gsel), .plunger_drive_out(pdrv), .plunger_hold_out(phld),
    .reset_request_n_out(rreq_n));
  pmpc_far_side far (.ref_clk_in(clk), .feed_phase_in(fph), .stuck_in(stuck),
    .enc_half_in(ehalf), .quad_step_in(qstep), .quad_dir_in(qdir),
    .carriage_encoder_out(cenc), .encoder_phase_a_out(ea), .encoder_phase_b_out(eb),
    .feed_phase_a_monitor_out(mon));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] ph(input int s);
    case (s)
      0: return fph;
      1: return rph;
      2: return gph;
      3: return bridge;
      4: return {2'b00, pdrv, phld};
      default: return {3'b000, rreq_n};
    endcase
  endfunction
  // Full step uses only the paired states of the eight-state walk
  function automatic logic [3:0] nxt(input logic [3:0] p, input bit up, input bit half);
    logic [3:0] t [8] = '{4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hC, 4'h8, 4'h9};
    int k;
    k = 0;
    for (int j = 0; j < 8; j++) if (t[j] == p) k = j;
    return t[(k + (up ? (half ? 1 : 2) : (half ? 7 : 6))) % 8];
  endfunction
  function automatic logic [1:0] fm(input logic [7:0] len, input logic pull);
    if (len < 8'h14) return pmpc_pkg::FEED_MICRO;
    if (len < 8'h3C || pull) return pmpc_pkg::FEED_MIDDLE;
    return pmpc_pkg::FEED_NORMAL;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic lim(input bit over);
    if (over) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic hw();
    int k;
    @(posedge clk);
    for (k = 0; k < 50 && hready !== 1'b1; k++) @(posedge clk);
    lim(k == 50);
  endtask
  // Trailing idle cycle lets a read-back see the previous write
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hwrite <= w;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hw();
    htrans <= 2'h0;
    hwdata <= wd;
    hw();
    rd = hrdata;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wait_on(input int s, input logic [3:0] v, input int k);
    int j;
    for (j = 0; j < k && ph(s) !== v; j++) @(posedge clk);
    lim(j == k);
  endtask
  // First change only aligns; the second fixes the walk direction
  task automatic watch(input int s, input int div, input bit half, output bit up);
    logic [3:0] p;
    int m;
    p = ph(s);
    up = 1'b0;
    for (int i = 0; i < 5; i++) begin
      for (m = 0; m < div + 40 && ph(s) === p; m++) @(posedge clk);
      lim(m == div + 40);
      if (i == 1) up = (ph(s) === nxt(p, 1'b1, half));
      if (i > 1) chk(m, div);
      if (i > 0) chk(ph(s), nxt(p, up, half));
      p = ph(s);
    end
  endtask

  initial begin
    {rstn, hsel, hwrite, stuck, qstep, qdir, htrans, ehalf, haddr, hwdata} = '0;
    hsize = 3'h2;
    tk(4);
    rstn <= 1'b1;
    hsel <= 1'b1;
    tk(1);
    rc(8'h00, 32'h0);
    rc(8'h08, 32'h000FFFFF);
    rc(8'h14, 32'hFFFFFFFF);
    wr(8'h18, rnd());
    rc(8'h18, 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    rc(8'h00, 32'h00000FFF);
    wr(8'h00, 32'h0);
    $display("registers done");
    for (int k = 0; k < 7; k++) begin
      wr(8'h0C, {24'h0, lens[k]});
      wr(8'h00, {27'h0, k == 6, 4'h0});
      bus(1'b0, 8'h10, 32'h0);
      chk({30'h0, rd[3:2]}, {30'h0, fm(lens[k], k == 6)});
    end
    d = 8'(rnd());
    wr(8'h0C, {24'h0, d | 8'h40});
    wr(8'h00, 32'h4);
    watch(0, FN, 1'b1, up0);
    wr(8'h00, 32'hC);
    watch(0, FN, 1'b1, up1);
    chk(up0 != up1, 1);
    wr(8'h0C, 32'h1E);
    watch(0, FM, 1'b1, up1);
    wr(8'h00, 32'h800);
    tk(3);
    chk($countones(fph), 1);
    wr(8'h00, 32'h0);
    tk(3);
    chk(fph, 0);
    $display("paper feed done");
    wr(8'h00, 32'h200);
    watch(1, RB, 1'b0, up0);
    wr(8'h00, 32'h0);
    tk(3);
    chk(rph, 0);
    wr(8'h00, 32'h40);
    watch(2, GP, 1'b0, up0);
    chk(gsel, 1);
    wr(8'h00, 32'h0);
    tk(3);
    chk(gsel, 0);
    chk($countones(gph), 2);
    for (int k = 0; k < 27; k++) begin
      qdir <= k > 19;
      qstep <= 1'b1;
      tk(1);
      qstep <= 1'b0;
      tk(7);
    end
    bus(1'b0, 8'h10, 32'h0);
    chk(rd[31:16], 16'h000D);
    $display("ribbon and gap done");
    d = 8'(rnd());
    up0 = d[0];
    ehalf <= 16'h0032;
    // Two encoder periods first, so the measured period is below threshold at go
    tk(250);
    wr(8'h08, 32'h190);
    wr(8'h04, {24'h0, d});
    wr(8'h00, {30'h0, up0, 1'b1});
    tk(40);
    n = 0;
    repeat (256) begin
      @(posedge clk);
      if (bridge === 4'h0) n++;
      else chk(bridge, `PMPC_BR_MODE1);
    end
    chk(n, d);
    watch(1, RB, 1'b0, up1);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd[1:0], 2'h1);
    ehalf <= 16'h00FA;
    d = up0 ? `PMPC_BR_MODE3_RL : `PMPC_BR_MODE3_LR;
    wait_on(3, d[3:0], 1200);
    chk(bridge, d[3:0]);
    ehalf <= 16'h0000;
    tk(1400);
    chk(bridge, d[3:0]);
    wait_on(3, `PMPC_BR_MODE1, 1200);
    chk(bridge, `PMPC_BR_MODE1);
    wr(8'h00, 32'h0);
    tk(3);
    chk(bridge, 0);
    $display("carriage done");
    wr(8'h00, 32'h20);
    tk(2);
    chk(ph(4), 2);
    wait_on(4, 4'h1, PL + 10);
    chk(ph(4), 1);
    wr(8'h00, 32'h0);
    tk(2);
    chk(ph(4), 0);
    wr(8'h00, 32'h404);
    tk(1500);
    chk(rreq_n, 1);
    stuck <= 1'b1;
    wait_on(5, 4'h0, WD + 100);
    chk(rreq_n, 0);
    rstn <= 1'b0;
    tk(2);
    rstn <= 1'b1;
    tk(2);
    chk(rreq_n, 1);
    $display("plunger and watchdog done");
    tally_and_finish();
  end
endmodule
